// ===== hw/tps_prescaler.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R01) Divider runs continuously, shared by both timers, ignoring their clock selects.
// (R02) First prescaled count comes 1 to N+1 cycles after start.
// (R03) Shared prescaler reset restarts divider phase for both timers.
// (R04) Select 1 ticks the timer every system clock cycle while the shared prescaler reset bit is clear.
// (R05) Divider offers taps at divide by 8, 64, 256 and 1024.
// (R06) Pin sampled each clock through latch stage and flip-flops into edge detector.
// (R07) One tick per rising edge on select 7, falling edge on select 6.
// (R08) Pin edge reaches counter tick two to three cycles after arrival.
// (R09) Software toggles external select only when pin stable one cycle.
// (R10) External clock half period exceeds one system clock cycle.
// (R11) External pin clock is never divided.
// (R12) Sync hold mode keeps written prescaler reset bits set, halting timers on selects 1 to 5.
// (R13) Clearing sync hold mode loads the written reset bits; written ones self-clear together a cycle later.
// (R14) Shared reset bit resets divider, self-clears unless sync hold mode.
// (R15) Select 0 stops, 2-5 pick taps, 6-7 pick pin edges.
// (R16) Pin transitions count even when pin is driven as output.
// (R17) Reset clears synchronisers, divider and control bits; no ticks follow.
module tps_prescaler
  import tps_pkg::*;
#(
  parameter int DIV_WIDTH = TPS_DIV_WIDTH
)
(
  // Clock and control
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  // Register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output logic      [7:0] regRdData,
  // External timer clock pins
  input  wire logic       timer0ExtClockIn,
  input  wire logic       timer1ExtClockIn,
  // Timer clock enables
  output logic            timer0Tick,
  output logic            timer1Tick,
  // Reset request to the asynchronous timer's own prescaler
  output logic            asyncPrescalerReset
);

  typedef struct packed {
    logic [DIV_WIDTH-1:0] divCount;
    logic [DIV_WIDTH-1:0] divPrev;
    logic                 syncHoldMode;
    logic                 sharedPrescalerReset;
    logic                 asyncPrescalerReset;
    logic [2:0]           t0Select;
    logic [2:0]           t1Select;
    logic [7:0]           rdData;
  } tps_state_t;

  tps_state_t stateReg;
  tps_state_t stateNext;

  logic ext0Tick;
  logic ext1Tick;
  logic pin0Level;
  logic pin1Level;

  // Falling edge of a divider bit marks one full tap period
  function automatic logic tapFire(input logic [DIV_WIDTH-1:0] cur,
                                   input logic [DIV_WIDTH-1:0] prv,
                                   input int tap);
    tapFire = cur[tap-1] == 1'b0 && prv[tap-1] == 1'b1;
  endfunction : tapFire

  // Map one clock-select field to a tick
  function automatic logic selTick(input logic [2:0] sel,
                                   input logic [DIV_WIDTH-1:0] cur,
                                   input logic [DIV_WIDTH-1:0] prv,
                                   input logic halted,
                                   input logic extT);
    selTick = 1'b0;
    if (sel == TPS_CS_DIV1) begin
      selTick = ~halted;                                  // R04
    end else if (sel == TPS_CS_DIV8) begin
      selTick = ~halted & tapFire(cur, prv, TPS_TAP8);    // R05 R15
    end else if (sel == TPS_CS_DIV64) begin
      selTick = ~halted & tapFire(cur, prv, TPS_TAP64);   // R05 R15
    end else if (sel == TPS_CS_D256) begin
      selTick = ~halted & tapFire(cur, prv, TPS_TAP256);  // R05 R15
    end else if (sel == TPS_CS_D1024) begin
      selTick = ~halted & tapFire(cur, prv, TPS_TAP1024); // R05 R15
    end else if (sel == TPS_CS_EXTF || sel == TPS_CS_EXTR) begin
      selTick = extT;                                     // R11 R15
    end
  endfunction : selTick

  // Pin synchronisers, one per timer
  tps_ext_sync u_sync0 (
    .clk              (clk),
    .rst_n            (rst_n),
    .clkEn            (clkEn),
    .extPin           (timer0ExtClockIn),
    .clockSelectField (stateReg.t0Select),
    .extTick          (ext0Tick),
    .pinLevel         (pin0Level)
  );

  tps_ext_sync u_sync1 (
    .clk              (clk),
    .rst_n            (rst_n),
    .clkEn            (clkEn),
    .extPin           (timer1ExtClockIn),
    .clockSelectField (stateReg.t1Select),
    .extTick          (ext1Tick),
    .pinLevel         (pin1Level)
  );

  // Next-state logic: divider, control bits, register reads
  always_comb begin
    stateNext        = stateReg;
    stateNext.rdData = 8'h00;

    // Free-running shared divider, held at zero while reset bit stands
    stateNext.divPrev = stateReg.divCount;
    if (stateReg.sharedPrescalerReset) begin
      stateNext.divCount = '0;                                   // R03 R14
      stateNext.divPrev  = '0;
    end else begin
      stateNext.divCount = stateReg.divCount + 1'b1;             // R01 R02
    end

    // Reset bits self-clear unless hold mode keeps them
    if (!stateReg.syncHoldMode) begin
      stateNext.sharedPrescalerReset = 1'b0;                     // R14
      stateNext.asyncPrescalerReset  = 1'b0;
    end

    if (regWrStb) begin
      if (regAddr == TPS_ADDR_SYNC_CTRL) begin
        stateNext.syncHoldMode = regWrData[TPS_SYNC_HOLD_BIT];
        if (regWrData[TPS_SYNC_HOLD_BIT]) begin
          // Written ones are kept while hold mode stays on
          stateNext.sharedPrescalerReset = regWrData[TPS_SHARED_PSR_BIT]; // R12
          stateNext.asyncPrescalerReset  = regWrData[TPS_ASYNC_PSR_BIT];  // R12
        end else begin
          // Leaving hold mode loads the written reset bits; written ones self-clear a cycle later
          stateNext.sharedPrescalerReset = regWrData[TPS_SHARED_PSR_BIT]; // R13 R14
          stateNext.asyncPrescalerReset  = regWrData[TPS_ASYNC_PSR_BIT];  // R13
        end
      end else if (regAddr == TPS_ADDR_CLK_SEL) begin
        stateNext.t0Select = regWrData[TPS_T0_SEL_LSB +: 3];     // R09
        stateNext.t1Select = regWrData[TPS_T1_SEL_LSB +: 3];     // R09
      end
    end

    if (regRdStb) begin
      if (regAddr == TPS_ADDR_SYNC_CTRL) begin
        stateNext.rdData[TPS_SYNC_HOLD_BIT]  = stateReg.syncHoldMode;
        stateNext.rdData[TPS_ASYNC_PSR_BIT]  = stateReg.asyncPrescalerReset;
        stateNext.rdData[TPS_SHARED_PSR_BIT] = stateReg.sharedPrescalerReset;
      end else if (regAddr == TPS_ADDR_CLK_SEL) begin
        stateNext.rdData[TPS_T0_SEL_LSB +: 3] = stateReg.t0Select;
        stateNext.rdData[TPS_T1_SEL_LSB +: 3] = stateReg.t1Select;
      end else if (regAddr == TPS_ADDR_STATUS) begin
        stateNext.rdData = {pin1Level, pin0Level,
                            stateReg.divCount[DIV_WIDTH-1 -: 6]};
      end
    end
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg                      <= '0;                       // R17
      stateReg.syncHoldMode         <= TPS_SYNC_CTRL_RST[TPS_SYNC_HOLD_BIT];
      stateReg.t0Select             <= TPS_CLK_SEL_RST[TPS_T0_SEL_LSB +: 3];
      stateReg.t1Select             <= TPS_CLK_SEL_RST[TPS_T1_SEL_LSB +: 3];
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  // Tick enables; a held reset halts prescaled and direct ticks
  assign timer0Tick = clkEn & selTick(stateReg.t0Select, stateReg.divCount,
                                      stateReg.divPrev, stateReg.sharedPrescalerReset,
                                      ext0Tick);   // R01 R15
  assign timer1Tick = clkEn & selTick(stateReg.t1Select, stateReg.divCount,
                                      stateReg.divPrev, stateReg.sharedPrescalerReset,
                                      ext1Tick);   // R01 R15

  assign regRdData           = stateReg.rdData;
  assign asyncPrescalerReset = stateReg.asyncPrescalerReset;

endmodule : tps_prescaler

`default_nettype wire

// ===== hw/tps_pkg.sv
package tps_pkg;

  // Register map (byte addresses on the plain register port)
  localparam logic [3:0] TPS_ADDR_SYNC_CTRL = 4'h0;  // timer_sync_control
  localparam logic [3:0] TPS_ADDR_CLK_SEL   = 4'h1;  // Both clock-select fields
  localparam logic [3:0] TPS_ADDR_STATUS    = 4'h2;  // Divider phase / pin state

  // timer_sync_control field positions
  localparam int TPS_SYNC_HOLD_BIT  = 7;
  localparam int TPS_ASYNC_PSR_BIT  = 1;
  localparam int TPS_SHARED_PSR_BIT = 0;

  // Clock-select register field positions
  localparam int TPS_T0_SEL_LSB = 0;
  localparam int TPS_T1_SEL_LSB = 4;

  // Reset values
  localparam logic [7:0] TPS_SYNC_CTRL_RST = 8'h00;
  localparam logic [7:0] TPS_CLK_SEL_RST   = 8'h00;

  // Divider and tap geometry
  localparam int TPS_DIV_WIDTH = 10;
  localparam int TPS_TAP8      = 3;
  localparam int TPS_TAP64     = 6;
  localparam int TPS_TAP256    = 8;
  localparam int TPS_TAP1024   = 10;

  // Clock-select encodings
  typedef enum logic [2:0] {
    TPS_CS_STOP  = 3'h0,
    TPS_CS_DIV1  = 3'h1,
    TPS_CS_DIV8  = 3'h2,
    TPS_CS_DIV64 = 3'h3,
    TPS_CS_D256  = 3'h4,
    TPS_CS_D1024 = 3'h5,
    TPS_CS_EXTF  = 3'h6,
    TPS_CS_EXTR  = 3'h7
  } tps_csel_t;

endpackage : tps_pkg

// ===== hw/tps_ext_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Pin synchroniser with edge detector for one external timer input
module tps_ext_sync
  import tps_pkg::*;
(
  // Clock and control
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  // Pin and selection
  input  wire logic extPin,
  input  wire logic [2:0] clockSelectField,
  // Outputs
  output logic      extTick,
  output logic      pinLevel
);

  typedef struct packed {
    logic latch;
    logic sync;
    logic prev;
  } tps_sync_state_t;

  tps_sync_state_t stateReg;
  tps_sync_state_t stateNext;

  // Sampling chain: latch stage, flip-flop, edge-history flip-flop
  always_comb begin
    stateNext       = stateReg;
    stateNext.latch = extPin;           // R06 R16
    stateNext.sync  = stateReg.latch;   // R06
    stateNext.prev  = stateReg.sync;    // R06
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg <= '0;                   // R17
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  // One pulse per selected edge; no divider on this path
  always_comb begin
    extTick = 1'b0;
    if (clockSelectField == TPS_CS_EXTR) begin
      extTick = stateReg.sync & ~stateReg.prev;   // R07 R11 R08
    end else if (clockSelectField == TPS_CS_EXTF) begin
      extTick = ~stateReg.sync & stateReg.prev;   // R07 R11 R08
    end
  end

  assign pinLevel = stateReg.sync;

endmodule : tps_ext_sync

`default_nettype wire

// ===== verif/tps_prescaler_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tps_prescaler_chk
  import tps_pkg::*;
(
  // Clock and control
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clkEn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrStb,
  input wire logic       regRdStb,
  input wire logic [7:0] regRdData,
  // Pins and ticks
  input wire logic       timer0ExtClockIn,
  input wire logic       timer1ExtClockIn,
  input wire logic       timer0Tick,
  input wire logic       timer1Tick,
  input wire logic       asyncPrescalerReset
);
  logic [2:0] sel0_reg;
  logic [2:0] sel1_reg;
  logic       hold_reg;
  logic       psr_reg;
  logic       async_prescaler_reset_reg;
  // Shadow of the select and control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {sel0_reg, sel1_reg, hold_reg, psr_reg, async_prescaler_reset_reg} <= '0;
    end else if (clkEn && regWrStb && regAddr == TPS_ADDR_CLK_SEL) begin
      sel0_reg <= regWrData[2:0];
      sel1_reg <= regWrData[6:4];
    end else if (clkEn && regWrStb && regAddr == TPS_ADDR_SYNC_CTRL) begin
      {hold_reg, async_prescaler_reset_reg, psr_reg} <= {regWrData[7], regWrData[1:0]};
    end else if (clkEn && !hold_reg) begin
      {async_prescaler_reset_reg, psr_reg} <= 2'b00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Tick relations to selects, pins and prescaler reset
  chk_div1_every: assert property (sel0_reg == TPS_CS_DIV1 |-> timer0Tick == !psr_reg)
    else $error("select one tick wrong");
  chk_stop_quiet: assert property (sel0_reg == 3'h0 && sel1_reg == 3'h0 |-> !timer0Tick && !timer1Tick)
    else $error("tick while stopped");
  // Pin change is seen one edge late; the tick stands two edges after that
  chk_rise_delay: assert property (sel1_reg == TPS_CS_EXTR && $rose(timer1ExtClockIn)
    |-> ##1 !timer1Tick ##1 timer1Tick ##1 !timer1Tick)
    else $error("rising edge tick timing wrong");
  chk_fall_delay: assert property (sel0_reg == TPS_CS_EXTF && $fell(timer0ExtClockIn)
    |-> ##1 !timer0Tick ##1 timer0Tick ##1 !timer0Tick)
    else $error("falling edge tick timing wrong");
  chk_rise_only: assert property (sel1_reg == TPS_CS_EXTR && $fell(timer1ExtClockIn)
    |-> ##1 !timer1Tick [*4])
    else $error("tick on wrong edge");
  chk_tap8_gap: assert property (sel0_reg == TPS_CS_DIV8 && timer0Tick |=> !timer0Tick [*7])
    else $error("divide by 8 ticks too close");
  chk_psr_halt: assert property (psr_reg && sel1_reg inside {[3'h1:3'h5]} |-> !timer1Tick)
    else $error("tick during prescaler reset");
  chk_async_bit: assert property (asyncPrescalerReset == async_prescaler_reset_reg)
    else $error("async reset request wrong");
  cover property (timer0Tick && sel0_reg == TPS_CS_DIV1);
  cover property (psr_reg && hold_reg);
  cover property (timer1Tick && sel1_reg == TPS_CS_EXTR);
endmodule : tps_prescaler_chk
`default_nettype wire

// ===== verif/tps_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
// Square wave on a timer pin, NPER periods per go pulse
module tps_ext_src #(
  parameter int HALF = 3,
  parameter int NPER = 4
) (
  // Clock and start
  input  wire logic clk,
  input  wire logic go,
  // Pin level
  output var logic  pin
);
  int ph = 0;
  int left = 0;
  initial pin = 1'b0;
  // Toggle every HALF cycles, then stand still and stable
  always @(posedge clk) begin
    if (go && left == 0) begin
      left <= 2 * NPER;
      ph   <= 0;
    end else if (left != 0 && ph == HALF - 1) begin
      pin  <= ~pin;
      left <= left - 1;
      ph   <= 0;
    end else if (left != 0) begin
      ph <= ph + 1;
    end
  end
endmodule : tps_ext_src
`default_nettype wire

// ===== verif/tps_prescaler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tps_prescaler_tb
  import tps_pkg::*;
;
  logic       clk, rst_n, clkEn, regWrStb, regRdStb, go;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic       timer0ExtClockIn, timer1ExtClockIn, timer0Tick, timer1Tick;
  logic       asyncPrescalerReset;
  int         err_count = 0, checked = 0, cyc = 0;
  // Design, two pin sources
  tps_prescaler #(.DIV_WIDTH(10)) DUT (.clk, .rst_n, .clkEn, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .timer0ExtClockIn, .timer1ExtClockIn,
    .timer0Tick, .timer1Tick, .asyncPrescalerReset);
  tps_ext_src #(.HALF(3), .NPER(4)) u_src0 (.clk, .go, .pin(timer0ExtClockIn));
  tps_ext_src #(.HALF(3), .NPER(4)) u_src1 (.clk, .go, .pin(timer1ExtClockIn));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic cmpN(input int got, input int exp);
    checked++;
    if (got != exp) begin
      err_count++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : cmpN
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge clk);
    regWrStb  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 cmp8(regRdData, exp);
  endtask : rd
  task automatic count(input int n, output int c0, output int c1);
    c0 = 0;
    c1 = 0;
    repeat (n) begin
      @(posedge clk);
      #1 c0 += int'(timer0Tick === 1'b1);
      c1 += int'(timer1Tick === 1'b1);
    end
  endtask : count
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (timer0Tick !== 1'b1 && c < 2000);
  endtask : wait_tick
  task automatic t_regs();
    rd(TPS_ADDR_SYNC_CTRL, TPS_SYNC_CTRL_RST);
    rd(TPS_ADDR_CLK_SEL, TPS_CLK_SEL_RST);
    wr(TPS_ADDR_CLK_SEL, 8'h75);
    rd(TPS_ADDR_CLK_SEL, 8'h75);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
  endtask : t_regs
  task automatic t_direct();
    int a, b;
    wr(TPS_ADDR_CLK_SEL, 8'h11);
    count(10, a, b);
    cmpN(a + b, 20);
    wr(TPS_ADDR_SYNC_CTRL, 8'h83);
    count(10, a, b);
    cmpN(a + b, 0);
    rd(TPS_ADDR_SYNC_CTRL, 8'h83);
    cmp8({7'h00, asyncPrescalerReset}, 8'h01);
    wr(TPS_ADDR_SYNC_CTRL, 8'h03);
    rd(TPS_ADDR_SYNC_CTRL, 8'h00);
    count(10, a, b);
    cmpN(a + b, 20);
  endtask : t_direct
  task automatic t_taps();
    int nTab[4] = '{8, 64, 256, 1024};
    int c;
    for (int i = 0; i < 4; i++) begin
      wr(TPS_ADDR_CLK_SEL, {1'b0, 3'(2 + i), 1'b0, 3'(2 + i)});
      wr(TPS_ADDR_SYNC_CTRL, 8'h01);
      wait_tick(c);
      cmpN(int'(c >= 1 && c <= nTab[i] + 1), 1);
      cmp8({7'h00, timer1Tick}, 8'h01);
      wait_tick(c);
      cmpN(c, nTab[i]);
    end
  endtask : t_taps
  task automatic t_ext();
    int a, b;
    wr(TPS_ADDR_SYNC_CTRL, 8'h81);
    wr(TPS_ADDR_CLK_SEL, 8'h76);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    count(40, a, b);
    cmpN(a, 4);
    cmpN(b, 4);
    rd(TPS_ADDR_STATUS, 8'h00);
    wr(TPS_ADDR_SYNC_CTRL, 8'h00);
  endtask : t_ext
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    {rst_n, regWrStb, regRdStb, go, regAddr, regWrData} = '0;
    clkEn = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_direct();
    t_taps();
    t_ext();
    print_verdict();
  end
endmodule : tps_prescaler_tb
bind tps_prescaler tps_prescaler_chk u_chk (.clk, .rst_n, .clkEn, .regAddr, .regWrData,
  .regWrStb, .regRdStb, .regRdData, .timer0ExtClockIn, .timer1ExtClockIn,
  .timer0Tick, .timer1Tick, .asyncPrescalerReset);
`default_nettype wire
